/* dv/gtp_event_src.sv */
// Purpose: timed equipment driving the two event inputs
// Assumes: edges launched just after a clock edge
// Notes:   never drives the secondary pulse pin
`timescale 1ns/1ps
module gtp_event_src (
   // clock
   input  wire logic clk_i,
   // event pins toward the unit
   output logic      event_input_zero_o,
   output logic      event_input_one_o
);
   // ==========================================================
   // pin drive
   // secondary pulse pin left alone, never pulled low
   initial begin
      event_input_zero_o = 1'b0;
      event_input_one_o = 1'b0;
   end

   // each level held at least 9 cycles, far above 50 ns, under 2.5 MHz
   task automatic put(input int ch, input logic v);
      @(posedge clk_i);
      if (ch == 0) begin
         event_input_zero_o <= v;
      end else begin
         event_input_one_o <= v;
      end
      repeat (8) @(posedge clk_i);
   endtask
endmodule

/* dv/gtp_unit_asserts.sv */
// Purpose: port level checks of the time pulse unit
// Assumes: one clock, synchronous active high reset
// Notes:   bound to every gtp_unit instance
`timescale 1ns/1ps
module gtp_unit_chk
   import gtp_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // register bus
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic [31:0] wb_dat_o,
   input  wire logic        wb_ack_o,
   // pins
   input  wire logic        primary_pulse_out_o,
   input  wire logic        secondary_pulse_out_o,
   input  wire logic        rx_on_o,
   input  wire logic        irq_o
);
   // ==========================================================
   // bus handshake
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_prompt: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   a_ack_cause: assert property (
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without a request");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside ack");

   // ==========================================================
   // pins
   // outputs still quiet at the first edge after release
   a_reset_state: assert property ($fell(rst_i) |-> !wb_ack_o &&
      !irq_o && rx_on_o && !primary_pulse_out_o &&
      !secondary_pulse_out_o)
      else $error("outputs not in reset state");
   // shortest legal period is 4, so both phases last 2 cycles
   a_prim_high: assert property (
      $rose(primary_pulse_out_o) |=> primary_pulse_out_o)
      else $error("primary high phase too short");
   a_prim_low: assert property (
      $fell(primary_pulse_out_o) |=> !primary_pulse_out_o)
      else $error("primary low phase too short");
   a_sec_high: assert property ($rose(secondary_pulse_out_o)
      |-> secondary_pulse_out_o ##1 secondary_pulse_out_o)
      else $error("secondary high phase too short");
endmodule

bind gtp_unit gtp_unit_chk u_chk (
   .clk_i,
   .rst_i,
   .wb_cyc_i,
   .wb_stb_i,
   .wb_dat_o,
   .wb_ack_o,
   .primary_pulse_out_o,
   .secondary_pulse_out_o,
   .rx_on_o,
   .irq_o
);

/* dv/gtp_unit_bench.sv */
// Purpose: self checking bench of the time pulse unit
// Assumes: short counts, 400 cycle default period
// Notes:   bus is classic single cycle wishbone
`timescale 1ns/1ps
module gtp_unit_bench
   import gtp_pkg::*;
;
   // ==========================================================
   // signals and instances
   logic        clk_i;
   logic        rst_i;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic [31:0] q;
   logic        ack;
   logic        ev0;
   logic        ev1;
   logic        p0;
   logic        p1;
   logic        rxon;
   logic        irq;
   int          bad_count;
   int          total_checks;

   gtp_unit #(
      .CYC_MS (32'd40),
      .PER_D  (32'd400),
      .PER_HI (32'(PER_MAX)),
      .PER_SLW(32'd200)
   ) DUT (
      .clk_i                (clk_i),
      .rst_i                (rst_i),
      .wb_cyc_i             (cyc),
      .wb_stb_i             (stb),
      .wb_we_i              (we),
      .wb_adr_i             (adr),
      .wb_sel_i             (sel),
      .wb_dat_i             (wdat),
      .wb_dat_o             (rdat),
      .wb_ack_o             (ack),
      .event_input_zero_i   (ev0),
      .event_input_one_i    (ev1),
      .primary_pulse_out_o  (p0),
      .secondary_pulse_out_o(p1),
      .rx_on_o              (rxon),
      .irq_o                (irq)
   );
   gtp_event_src src (
      .clk_i             (clk_i),
      .event_input_zero_o(ev0),
      .event_input_one_o (ev1)
   );

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // ==========================================================
   // shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // holds the request until ack is sampled, takes data there
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 64);
      q = rdat;
      if (n >= 64) chk(32'h0, 32'h1);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(q, e);
   endtask

   task automatic fld(input logic [7:0] a, input int b, input logic v);
      wb(1'b0, a, 32'h0);
      chk(32'(q[b]), 32'(v));
   endtask

   // period and high time between two rising edges
   task automatic meas(input int ch, input int p, input int h);
      int n, c, k, m;
      logic prv, cur;
      n = 0;
      c = 0;
      k = 0;
      m = 0;
      prv = 1'b1;
      while (n < 3000 && c < 2) begin
         @(posedge clk_i);
         cur = (ch == 0) ? p0 : p1;
         if (prv === 1'b0 && cur === 1'b1) c++;
         if (c == 1) begin
            k++;
            if (cur === 1'b1) m++;
         end
         prv = cur;
         n++;
      end
      chk(32'(k), 32'(p));
      chk(32'(m), 32'(h));
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset;
      rd(A_CTRL, 32'h1);
      rd(A_PER0, 32'd400);
      rd(A_ACCURACY_THRESHOLD, 32'hffffffff);
      // duty cycling off, unit runs continuously
      chk(32'(rxon), 32'h1);
      wb(1'b1, 8'h7c, 32'h5a);
      rd(8'h7c, 32'h0);
      $display("t_reset done");
   endtask

   task automatic t_pulses;
      meas(0, 400, 200);
      wb(1'b1, A_PER1, 32'd4);
      wb(1'b1, A_CTRL, 32'h3);
      meas(1, 4, 2);
      wb(1'b1, A_PER1, 32'd2);
      meas(1, 4, 2);
      wb(1'b1, A_CTRL, 32'h1);
      $display("t_pulses done");
   endtask

   task automatic t_irq;
      int n;
      n = 0;
      wb(1'b1, A_STATUS, 32'hff);
      wb(1'b1, A_MASK, 32'h1);
      while (irq !== 1'b1 && n < 900) begin
         @(posedge clk_i);
         n++;
      end
      chk(32'(irq), 32'h1);
      wb(1'b0, A_STATUS, 32'h0);
      chk(q & 32'h7, 32'h5);
      wb(1'b1, A_STATUS, 32'h5);
      repeat (2) @(posedge clk_i);
      chk(32'(irq), 32'h0);
      wb(1'b1, A_MASK, 32'h0);
      $display("t_irq done");
   endtask

   task automatic t_events;
      src.put(0, 1'b1);
      src.put(0, 1'b0);
      rd(8'h90, 32'h0);
      fld(A_STATUS, S_EV0, 1'b0);
      wb(1'b1, A_CTRL, 32'h11);
      src.put(0, 1'b1);
      src.put(0, 1'b0);
      src.put(1, 1'b1);
      rd(8'h90, 32'h2);
      rd(8'hb0, 32'h1);
      wb(1'b0, A_STATUS, 32'h0);
      chk(q & 32'h18, 32'h18);
      wb(1'b1, A_AID_MS, 32'h1000);
      src.put(0, 1'b1);
      rd(A_TIME_MS, 32'h1000);
      rd(A_AID_MS, 32'h2000);
      $display("t_events done");
   endtask

   task automatic t_integrity;
      wb(1'b1, A_SIGNALS, 32'h5);
      fld(A_SIGNALS, 16, 1'b1);
      wb(1'b1, A_SIGNALS, 32'h4);
      fld(A_SIGNALS, 16, 1'b0);
      wb(1'b1, A_ACCURACY_THRESHOLD, 32'd10);
      wb(1'b1, A_TUNC, 32'd20);
      wb(1'b1, A_STATUS, 32'hff);
      repeat (900) @(posedge clk_i);
      fld(A_STATUS, S_PULSE0, 1'b0);
      fld(A_SIGNALS, 19, 1'b1);
      wb(1'b1, A_CTRL, 32'h21);
      repeat (900) @(posedge clk_i);
      fld(A_STATUS, S_PULSE0, 1'b1);
      $display("t_integrity done");
   endtask

   task automatic t_fixed;
      wb(1'b1, A_CTRL, 32'h201);
      fld(A_SIGNALS, 17, 1'b0);
      wb(1'b1, A_POS_UNC, 32'h1);
      fld(A_SIGNALS, 17, 1'b1);
      fld(A_SIGNALS, 16, 1'b1);
      $display("t_fixed done");
   endtask

   task automatic t_modes;
      wb(1'b1, A_CIV_MS, 32'h100);
      wb(1'b1, A_CTRL, 32'h5);
      fld(A_SIGNALS, 20, 1'b0);
      wb(1'b1, A_CTRL, 32'hd);
      fld(A_SIGNALS, 20, 1'b1);
      wb(1'b1, A_CTRL, 32'h1);
      fld(A_SIGNALS, 17, 1'b0);
      wb(1'b1, A_SV_STD, 32'd5);
      wb(1'b1, A_SV_LIM, 32'd3);
      wb(1'b1, A_CTRL, 32'h101);
      repeat (4) @(posedge clk_i);
      fld(A_SIGNALS, 17, 1'b0);
      wb(1'b1, A_STATUS, 32'hff);
      wb(1'b1, A_SV_LIM, 32'd5);
      fld(A_SIGNALS, 17, 1'b1);
      fld(A_STATUS, S_SURVEY, 1'b1);
      $display("t_modes done");
   endtask

   // ==========================================================
   // run control
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      rst_i = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h0;
      sel = 4'hf;
      wdat = 32'h0;
      bad_count = 0;
      total_checks = 0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_pulses();
      t_irq();
      t_events();
      t_integrity();
      t_fixed();
      t_modes();
      tally_and_finish();
   end

   // whole run needs about 3200 cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      bad_count++;
      tally_and_finish();
   end
endmodule

/* logic/gtp_unit.sv */
// Purpose: two grid pulse outputs, two edge time markers, time mode
// Assumes: one 40 MHz clock, software feeds navigation figures
// Notes:   all state sits in one packed struct register
//
// How it works
// - two pulse outputs, 0.25 Hz to 10 MHz
// - grid civil or satellite; civil needs calibration
// - clock-edge pulses; slow primary rates pre-report next phase
// - solution time is most recent emitted primary pulse
// - reset enables primary pulse at one hertz
// - enabled marking stamps both edges, counts, reports
// - stamps use the pulse alignment grid
// - marking off until enable written
// - survey ends at std limit and time
// - fixed via survey end or entered position
// - fixed mode needs one signal, raisable
// - protection flag when signals exceed minimum
// - uncertainty above threshold gates the pulse
// - aid pulse plus time message sets milliseconds
// - duty cycling needs power save and on/off
//
// Chosen here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module gtp_unit
   import gtp_pkg::*;
#(
   parameter logic [31:0] CYC_MS  = 32'(CYC_PER_MS),
   parameter logic [31:0] PER_D   = 32'(PER_DEF),
   parameter logic [31:0] PER_HI  = 32'(PER_MAX),
   parameter logic [31:0] PER_SLW = 32'(PER_SLOW)
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // pins
   input  wire logic        event_input_zero_i,
   input  wire logic        event_input_one_i,
   output logic             primary_pulse_out_o,
   output logic             secondary_pulse_out_o,
   output logic             rx_on_o,
   output logic             irq_o
);
   // ==========================================================
   // state
   typedef struct packed {
      logic             ack;
      logic [31:0]      rdat;
      logic [10:0]      ctrl;
      logic [1:0][31:0] per;
      logic [1:0][31:0] pcnt;
      logic [1:0]       pout;
      logic [5:0]       sts;
      logic [5:0]       msk;
      logic             irq;
      logic [31:0]      cyc;
      logic [31:0]      ms;
      logic [31:0]      sub;
      logic [9:0]       msdiv;
      logic [31:0]      last_ms;
      logic [31:0]      next_cyc;
      logic [7:0]       sv_use;
      logic [7:0]       sv_min;
      logic [31:0]      tunc;
      logic [31:0]      accuracy_threshold;
      logic [31:0]      svstd;
      logic [31:0]      svlim;
      logic [31:0]      svmin;
      logic [31:0]      svel;
      logic [31:0]      pos_unc;
      logic [31:0]      aid_ms;
      logic             aid_pend;
      logic [31:0]      civ_ms;
      logic [31:0]      dper;
      logic [31:0]      dto;
      logic [31:0]      dsec;
      logic             rx_on;
      gtp_tm_t          tm;
      logic [1:0][2:0]  sync;
      logic [1:0]       lvl;
      logic [1:0][31:0] rms;
      logic [1:0][31:0] rsub;
      logic [1:0][31:0] fms;
      logic [1:0][31:0] fsub;
      logic [1:0][31:0] ecnt;
   } gtp_st_t;

   gtp_st_t q;
   gtp_st_t d;

   function automatic logic [31:0] bmerge(input logic [31:0] o,
                                          input logic [31:0] n,
                                          input logic [3:0]  s);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            r[8*b +: 8] = n[8*b +: 8];
         end
      end
      return r;
   endfunction

   logic [1:0]  pin;
   assign pin = {event_input_one_i, event_input_zero_i};

   // ==========================================================
   // next state
   always_comb begin
      logic        acc;
      logic        wr;
      logic        tick_s;
      logic        civ_ok;
      logic        gate;
      logic        fixed;
      logic        aid_hit;
      logic [5:0]  evt;
      logic [5:0]  clr;
      logic [31:0] wv;
      logic [31:0] rd;
      logic [31:0] rep_ms;
      logic [31:0] perc;
      logic [7:0]  min_req;
      logic [7:0]  ea;
      logic        edge_seen;
      logic        stop;
      d       = q;
      acc     = wb_cyc_i & wb_stb_i;
      wr      = acc & wb_we_i & q.ack;
      evt     = '0;
      clr     = '0;
      tick_s  = 1'b0;
      aid_hit = 1'b0;
      perc    = '0;
      ea      = '0;
      edge_seen = 1'b0;
      stop    = 1'b0;
      rd      = '0;
      wv      = '0;
      d.ack   = acc & ~q.ack;

      // civil grid only when the offset is known
      civ_ok = q.ctrl[C_CIVIL] & q.ctrl[C_CALIB];
      rep_ms = civ_ok ? q.ms + q.civ_ms : q.ms;
      fixed  = (q.tm == TM_FIXED);
      // one signal suffices when the position is pinned
      min_req = fixed ? ((q.sv_min < MIN_SV_FIXED) ? MIN_SV_FIXED
                                                   : q.sv_min)
                      : MIN_SV_NAV;
      gate = (q.tunc > q.accuracy_threshold) & ~q.ctrl[C_GATEMOD];

      // time base: millisecond count plus sub-millisecond cycles
      d.cyc = q.cyc + 32'h1;
      if (q.sub >= CYC_MS - 32'h1) begin
         d.sub = '0;
         d.ms  = q.ms + 32'h1;
         if (q.msdiv == 10'(MS_PER_S - 1)) begin
            d.msdiv = '0;
            tick_s  = 1'b1;
         end else begin
            d.msdiv = q.msdiv + 10'h1;
         end
      end else begin
         d.sub = q.sub + 32'h1;
      end

      // event inputs: three stages, change once stages 2, 3 agree
      for (int c = 0; c < 2; c++) begin
         d.sync[c] = {q.sync[c][1:0], pin[c]};
         edge_seen = (q.sync[c][1] == q.sync[c][2]) &&
                     (q.sync[c][2] != q.lvl[c]);
         if (edge_seen) begin
            d.lvl[c] = q.sync[c][2];
            if (c == 0 && q.sync[c][2] && q.aid_pend) begin
               aid_hit = 1'b1;
            end
            if (q.ctrl[C_MARK]) begin
               if (q.sync[c][2]) begin
                  d.rms[c]  = rep_ms;
                  d.rsub[c] = q.sub;
               end else begin
                  d.fms[c]  = rep_ms;
                  d.fsub[c] = q.sub;
               end
               d.ecnt[c] = q.ecnt[c] + 32'h1;
               evt[S_EV0 + c] = 1'b1;
            end
         end
      end

      // aid edge plus pending message loads whole milliseconds
      if (aid_hit) begin
         d.ms       = q.aid_ms;
         d.sub      = '0;
         d.msdiv    = '0;
         d.aid_pend = 1'b0;
      end

      // pulse generators; a stop waits out a high phase, no runts
      for (int c = 0; c < 2; c++) begin
         perc = q.per[c];
         if (perc < 32'(PER_MIN)) begin
            perc = 32'(PER_MIN);
         end else if (perc > PER_HI) begin
            perc = PER_HI;
         end
         stop = !q.ctrl[C_P0_EN + c] || gate || (q.tm == TM_SURVEY);
         if (stop && !q.pout[c]) begin
            d.pcnt[c] = perc - 32'h1;   // resume with a pulse start
            d.pout[c] = 1'b0;
         end else if (aid_hit) begin
            d.pcnt[c] = perc - 32'h1;
            d.pout[c] = q.pout[c];
         end else if (!stop && q.pcnt[c] >= perc - 32'h1) begin
            // edges fall on clock edges, jitter one cycle
            d.pcnt[c] = '0;
            d.pout[c] = 1'b1;
            evt[S_PULSE0 + c] = 1'b1;
            if (c == 0) begin
               d.last_ms = rep_ms;
               if (perc > PER_SLW) begin
                  d.next_cyc = q.cyc + perc + 32'h1;
                  evt[S_PHASE] = 1'b1;
               end
            end
         end else begin
            d.pcnt[c] = q.pcnt[c] + 32'h1;
            d.pout[c] = (q.pcnt[c] + 32'h1) < (perc >> 1);
         end
      end

      // time mode
      case (q.tm)
         TM_OFF: begin
            if (q.ctrl[C_TMODE +: 2] == TMODE_SURVEY) begin
               d.tm   = TM_SURVEY;
               d.svel = '0;
            end
         end
         TM_SURVEY: begin
            if (tick_s) begin
               d.svel = q.svel + 32'h1;
            end
            if (q.ctrl[C_TMODE +: 2] == TMODE_OFF) begin
               d.tm = TM_OFF;
            end else if (q.svstd <= q.svlim && q.svel >= q.svmin) begin
               d.tm = TM_FIXED;
               evt[S_SURVEY] = 1'b1;
            end
         end
         TM_FIXED: begin
            if (q.ctrl[C_TMODE +: 2] == TMODE_OFF) begin
               d.tm = TM_OFF;
            end
         end
         default: begin
            d.tm = TM_OFF;
         end
      endcase

      // low duty cycle: on for timeout seconds of each period
      if (q.ctrl[C_PSAVE] & q.ctrl[C_ONOFF]) begin
         if (tick_s) begin
            d.dsec  = (q.dsec + 32'h1 >= q.dper) ? '0 : q.dsec + 32'h1;
            d.rx_on = d.dsec < q.dto;
         end
      end else begin
         d.dsec  = '0;
         d.rx_on = 1'b1;
      end

      // register writes
      if (wr) begin
         case (wb_adr_i)
            A_CTRL: begin
               wv = bmerge({21'h0, q.ctrl}, wb_dat_i, wb_sel_i);
               d.ctrl = wv[10:0];
            end
            A_PER0:    d.per[0] = bmerge(q.per[0], wb_dat_i, wb_sel_i);
            A_PER1:    d.per[1] = bmerge(q.per[1], wb_dat_i, wb_sel_i);
            A_STATUS: begin
               wv  = bmerge(32'h0, wb_dat_i, wb_sel_i);
               clr = wv[5:0];
            end
            A_MASK: begin
               wv    = bmerge({26'h0, q.msk}, wb_dat_i, wb_sel_i);
               d.msk = wv[5:0];
            end
            A_SIGNALS: begin
               wv = bmerge({16'h0, q.sv_min, q.sv_use}, wb_dat_i,
                           wb_sel_i);
               d.sv_use = wv[7:0];
               d.sv_min = wv[15:8];
            end
            A_TUNC:    d.tunc  = bmerge(q.tunc, wb_dat_i, wb_sel_i);
            A_ACCURACY_THRESHOLD:    d.accuracy_threshold  = bmerge(q.accuracy_threshold, wb_dat_i, wb_sel_i);
            A_SV_STD:  d.svstd = bmerge(q.svstd, wb_dat_i, wb_sel_i);
            A_SV_LIM:  d.svlim = bmerge(q.svlim, wb_dat_i, wb_sel_i);
            A_SV_MIN:  d.svmin = bmerge(q.svmin, wb_dat_i, wb_sel_i);
            A_POS_UNC: begin
               d.pos_unc = bmerge(q.pos_unc, wb_dat_i, wb_sel_i);
               if (q.ctrl[C_TMODE +: 2] == TMODE_FIXED) begin
                  d.tm = TM_FIXED;
               end
            end
            A_AID_MS: begin
               d.aid_ms   = bmerge(q.aid_ms, wb_dat_i, wb_sel_i);
               d.aid_pend = 1'b1;
            end
            A_CIV_MS:  d.civ_ms = bmerge(q.civ_ms, wb_dat_i, wb_sel_i);
            A_DUTY_PER: d.dper = bmerge(q.dper, wb_dat_i, wb_sel_i);
            A_DUTY_TO: d.dto   = bmerge(q.dto, wb_dat_i, wb_sel_i);
            default: begin
            end
         endcase
      end

      // sticky status: a new event beats a same-cycle clear
      d.sts = (q.sts & ~clr) | evt;
      d.irq = |(d.sts & d.msk);

      // read mux, unmapped reads return zero
      case (wb_adr_i)
         A_CTRL:     rd = {21'h0, q.ctrl};
         A_PER0:     rd = q.per[0];
         A_PER1:     rd = q.per[1];
         A_STATUS:   rd = {26'h0, q.sts};
         A_MASK:     rd = {26'h0, q.msk};
         A_TIME_MS:  rd = rep_ms;
         A_TIME_SUB: rd = q.sub;
         A_CYCLE:    rd = q.cyc;
         A_LAST_MS:  rd = q.last_ms;
         A_NEXT_CYC: rd = q.next_cyc;
         // protection flag, fixed and uncertainty-above-threshold live here
         A_SIGNALS:  rd = {11'h0, civ_ok, q.tunc > q.accuracy_threshold,
                           q.sv_use >= min_req, fixed,
                           q.sv_use > min_req, q.sv_min, q.sv_use};
         A_TUNC:     rd = q.tunc;
         A_ACCURACY_THRESHOLD:     rd = q.accuracy_threshold;
         A_SV_STD:   rd = q.svstd;
         A_SV_LIM:   rd = q.svlim;
         A_SV_MIN:   rd = q.svmin;
         A_SV_EL:    rd = q.svel;
         A_POS_UNC:  rd = q.pos_unc;
         A_AID_MS:   rd = {q.aid_ms[30:0], q.aid_pend};
         A_CIV_MS:   rd = q.civ_ms;
         A_DUTY_PER: rd = q.dper;
         A_DUTY_TO:  rd = q.dto;
         default: begin
            for (int c = 0; c < 2; c++) begin
               ea = A_EV_BASE + 8'(c) * A_EV_STRIDE;
               if (wb_adr_i == ea + F_RISE_MS)  rd = q.rms[c];
               if (wb_adr_i == ea + F_RISE_SUB) rd = q.rsub[c];
               if (wb_adr_i == ea + F_FALL_MS)  rd = q.fms[c];
               if (wb_adr_i == ea + F_FALL_SUB) rd = q.fsub[c];
               if (wb_adr_i == ea + F_COUNT)    rd = q.ecnt[c];
            end
         end
      endcase
      d.rdat = (acc & ~q.ack) ? rd : '0;
   end

   // ==========================================================
   // registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q        <= '0;
         q.ctrl   <= CTRL_RST;
         q.per[0] <= PER_D;
         q.per[1] <= PER_D;
         q.sv_min <= MIN_SV_FIXED;
         q.accuracy_threshold   <= ACCURACY_THRESHOLD_RST;
         q.rx_on  <= 1'b1;
         q.tm     <= TM_OFF;
      end else begin
         q <= d;
      end
   end

   // outputs straight from flops; secondary idles low, host
   // must not hold it low at start-up
   assign wb_dat_o              = q.rdat;
   assign wb_ack_o              = q.ack;
   assign primary_pulse_out_o   = q.pout[0];
   assign secondary_pulse_out_o = q.pout[1];
   assign rx_on_o               = q.rx_on;
   assign irq_o                 = q.irq;
endmodule

/* pkg/gtp_pkg.sv */
// Purpose: constants shared by the time pulse and event mark unit
// Assumes: 40 MHz system clock, classic Wishbone register access
// Notes:   offsets are byte addresses of 32-bit words
package gtp_pkg;
   // ==========================================================
   // timing
   localparam int CLK_HZ         = 40_000_000;
   localparam int PULSE_MAX_HZ   = 10_000_000;
   localparam int PULSE_MIN_QHZ  = 1;          // quarter hertz units
   localparam int REPORT_BELOW_HZ = 2;
   localparam int DEF_RATE_HZ    = 1;
   localparam int MS_PER_S       = 1000;
   localparam int CYC_PER_MS     = CLK_HZ / MS_PER_S;
   localparam int PER_MIN        = CLK_HZ / PULSE_MAX_HZ;
   localparam int PER_MAX        = (CLK_HZ * 4) / PULSE_MIN_QHZ;
   localparam int PER_SLOW       = CLK_HZ / REPORT_BELOW_HZ;
   localparam int PER_DEF        = CLK_HZ / DEF_RATE_HZ;
   localparam logic [7:0] MIN_SV_FIXED = 8'h01;
   localparam logic [7:0] MIN_SV_NAV   = 8'h04;

   // ==========================================================
   // register offsets
   localparam logic [7:0] A_CTRL    = 8'h00;
   localparam logic [7:0] A_PER0    = 8'h04;
   localparam logic [7:0] A_PER1    = 8'h08;
   localparam logic [7:0] A_STATUS  = 8'h0c;
   localparam logic [7:0] A_MASK    = 8'h10;
   localparam logic [7:0] A_TIME_MS = 8'h14;
   localparam logic [7:0] A_TIME_SUB = 8'h18;
   localparam logic [7:0] A_CYCLE   = 8'h1c;
   localparam logic [7:0] A_LAST_MS = 8'h20;
   localparam logic [7:0] A_NEXT_CYC = 8'h24;
   localparam logic [7:0] A_SIGNALS = 8'h28;
   localparam logic [7:0] A_TUNC    = 8'h2c;
   localparam logic [7:0] A_ACCURACY_THRESHOLD    = 8'h30;
   localparam logic [7:0] A_SV_STD  = 8'h34;
   localparam logic [7:0] A_SV_LIM  = 8'h38;
   localparam logic [7:0] A_SV_MIN  = 8'h3c;
   localparam logic [7:0] A_SV_EL   = 8'h40;
   localparam logic [7:0] A_POS_UNC = 8'h44;
   localparam logic [7:0] A_AID_MS  = 8'h48;
   localparam logic [7:0] A_CIV_MS  = 8'h4c;
   localparam logic [7:0] A_DUTY_PER = 8'h50;
   localparam logic [7:0] A_DUTY_TO = 8'h54;
   localparam logic [7:0] A_EV_BASE = 8'h80;
   localparam logic [7:0] A_EV_STRIDE = 8'h20;
   localparam logic [7:0] F_RISE_MS = 8'h00;
   localparam logic [7:0] F_RISE_SUB = 8'h04;
   localparam logic [7:0] F_FALL_MS = 8'h08;
   localparam logic [7:0] F_FALL_SUB = 8'h0c;
   localparam logic [7:0] F_COUNT   = 8'h10;

   // ==========================================================
   // control bits
   localparam int C_P0_EN  = 0;
   localparam int C_P1_EN  = 1;
   localparam int C_CIVIL  = 2;
   localparam int C_CALIB  = 3;
   localparam int C_MARK   = 4;
   localparam int C_GATEMOD = 5;
   localparam int C_PSAVE  = 6;
   localparam int C_ONOFF  = 7;
   localparam int C_TMODE  = 8;   // two bits
   localparam int C_POSFMT = 10;
   localparam logic [1:0] TMODE_OFF    = 2'h0;
   localparam logic [1:0] TMODE_SURVEY = 2'h1;
   localparam logic [1:0] TMODE_FIXED  = 2'h2;
   localparam logic [10:0] CTRL_RST    = 11'h001;

   // ==========================================================
   // status bits
   localparam int S_PULSE0 = 0;
   localparam int S_PULSE1 = 1;
   localparam int S_PHASE  = 2;
   localparam int S_EV0    = 3;
   localparam int S_SURVEY = 5;
   localparam logic [31:0] ACCURACY_THRESHOLD_RST = 32'hffffffff;

   typedef enum logic [1:0] { TM_OFF, TM_SURVEY, TM_FIXED } gtp_tm_t;
endpackage
